// ### design/line_pad.sv
// Output path of one port: direction, alternate merge, open drain
`timescale 1ns/10ps
module line_pad #(
	parameter int W = 16,
	parameter logic [W-1:0] DRIVE_LINES = 16'hFFFF,
	parameter logic [W-1:0] OD_LINES = 16'hFFFF,
	parameter logic [W-1:0] PWM_LINES = 16'h0000,
	parameter logic [W-1:0] AUTO_LINES = 16'h0000
) (
	input logic core_clk_i,
	input logic sys_rst_i,
	input logic [W-1:0] latch_i,
	input logic [W-1:0] dir_i,
	input logic [W-1:0] od_i,
	input logic [W-1:0] alt_en_i,
	input logic [W-1:0] alt_data_i,
	input logic [W-1:0] hw_en_i,
	input logic [W-1:0] hw_out_i,
	input logic [W-1:0] hw_data_i,
	output logic [W-1:0] pin_o,
	output logic [W-1:0] pin_oe_o
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [W-1:0] out;
		logic [W-1:0] oe;
	} pad_t;
	pad_t st_r;
	pad_t st_nxt;
	logic [W-1:0] eff_dir;
	logic [W-1:0] alt_val;
	logic [W-1:0] val;
	logic [W-1:0] release_l;
	assign eff_dir = (hw_en_i & hw_out_i)
		| (~hw_en_i & (dir_i | (AUTO_LINES & alt_en_i)));
	// Latch gates the alternate data; modulator lines bypass it
	assign alt_val = (~PWM_LINES & latch_i & (~alt_en_i | alt_data_i))
		| (PWM_LINES & ((alt_en_i & alt_data_i) | (~alt_en_i & latch_i)));
	assign val = (hw_en_i & hw_data_i) | (~hw_en_i & alt_val);
	assign release_l = od_i & OD_LINES & ~hw_en_i & val;
	always_comb begin
		st_nxt.oe = eff_dir & DRIVE_LINES & ~release_l;
		st_nxt.out = val & st_nxt.oe;
		if (sys_rst_i) begin
			st_nxt = '0;
		end
	end
	always_ff @(posedge core_clk_i) begin
		st_r <= st_nxt;
	end
	assign pin_o = st_r.out;
	assign pin_oe_o = st_r.oe;
	// ==========================================================
	// Checks
	property p_no_dir_no_drive;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		##1 (pin_oe_o & ~$past(eff_dir)) == '0;
	endproperty
	a_no_dir_no_drive: assert property (p_no_dir_no_drive)
		else $error("pin driven while line is an input");
	property p_od_release;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		##1 (pin_oe_o & $past(od_i & OD_LINES & ~hw_en_i & val)) == '0;
	endproperty
	a_od_release: assert property (p_od_release)
		else $error("open drain line drove a high level");
	property p_out_drives;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		##1 (($past(eff_dir & DRIVE_LINES & ~release_l) & ~pin_oe_o)
			| (pin_o ^ ($past(val) & pin_oe_o))) == '0;
	endproperty
	a_out_drives: assert property (p_out_drives)
		else $error("output line not driven with its value");
endmodule : line_pad

// ### design/line_sampler.sv
// Pin synchroniser and level filter for one port
`timescale 1ns/10ps
module line_sampler #(
	parameter int W = 16
) (
	input logic core_clk_i,
	input logic sys_rst_i,
	input logic [W-1:0] pin_i,
	input logic [W-1:0] hys_i,
	output logic [W-1:0] level_o
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] s4;
		logic [W-1:0] level;
	} samp_t;
	samp_t st_r;
	samp_t st_nxt;
	logic [W-1:0] agree;
	// Hysteresis lines need one more matching sample to switch
	assign agree = ~(st_r.s2 ^ st_r.s3) & (~hys_i | ~(st_r.s3 ^ st_r.s4));
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.s4 = st_r.s3;
		st_nxt.level = (agree & st_r.s3) | (~agree & st_r.level);
		if (sys_rst_i) begin
			st_nxt = '0;
		end
	end
	always_ff @(posedge core_clk_i) begin
		st_r <= st_nxt;
	end
	assign level_o = st_r.level;
	// ==========================================================
	// Checks
	property p_level_follows;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		##1 ((level_o ^ $past(st_r.s3)) & $past(agree)) == '0;
	endproperty
	a_level_follows: assert property (p_level_follows)
		else $error("sampled level did not follow agreeing samples");
	property p_hys_hold;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		##1 ((level_o ^ $past(level_o)) & $past(hys_i)
			& $past(st_r.s3 ^ st_r.s4)) == '0;
	endproperty
	a_hys_hold: assert property (p_hys_hold)
		else $error("hysteresis line switched without extra sample");
endmodule : line_sampler

// ### design/parallel_io_pkg.sv
// Shared constants and carrier types for the parallel port block
package parallel_io_pkg;
	// ==========================================================
	// Geometry
	localparam int PORT_COUNT = 9;
	localparam int LANE_W = 16;
	localparam int ADDR_W = 8;
	localparam int THR_W = 9;
	localparam int XTHR_W = 4;
	typedef logic [LANE_W-1:0] lane_t;
	typedef logic [PORT_COUNT-1:0][LANE_W-1:0] lane_arr_t;
	// ==========================================================
	// Register map: addr[7:4] selects the port, addr[3:0] the register
	localparam logic [3:0] OFS_DATA = 4'h0;
	localparam logic [3:0] OFS_DIR = 4'h4;
	localparam logic [3:0] OFS_OD = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_THR = 8'h90;
	localparam logic [ADDR_W-1:0] ADDR_XTHR = 8'h94;
	localparam logic [ADDR_W-1:0] ADDR_PORT0_LOW_HALF = 8'hA0;
	localparam logic [ADDR_W-1:0] ADDR_PORT0_HIGH_HALF = 8'hA4;
	localparam logic [ADDR_W-1:0] ADDR_PORT1_LOW_HALF = 8'hA8;
	localparam logic [ADDR_W-1:0] ADDR_PORT1_HIGH_HALF = 8'hAC;
	localparam logic [ADDR_W-1:0] ADDR_P2_DATA = 8'h20;
	// ==========================================================
	// Threshold bit positions
	localparam int THR_PORT0_LOW_HALF = 0;
	localparam int THR_PORT0_HIGH_HALF = 1;
	localparam int THR_PORT1_LOW_HALF = 2;
	localparam int THR_PORT1_HIGH_HALF = 3;
	localparam int THR_P2L = 4;
	localparam int THR_P2H = 5;
	localparam int THR_P3L = 6;
	localparam int THR_P3H = 7;
	localparam int THR_P4 = 8;
	localparam int XTHR_P5L = 0;
	localparam int XTHR_P5H = 1;
	localparam int XTHR_P7 = 2;
	localparam int XTHR_P8 = 3;
	// ==========================================================
	// Reset values and lane masks, port 8 leftmost
	localparam lane_t LATCH_RST = 16'h0000;
	localparam lane_t DIR_RST = 16'h0000;
	localparam lane_t OD_RST = 16'h0000;
	localparam lane_arr_t IMPL_MASK = {16'h00FF, 16'h00FF, 16'h00FF,
		16'hFFFF, 16'h00FF, 16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	localparam lane_arr_t DRIVE_MASK = {16'h00FF, 16'h00FF, 16'h00FF,
		16'h0000, 16'h00FF, 16'hBFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
	localparam lane_arr_t OD_MASK = {16'h00FF, 16'h00FF, 16'h00FF,
		16'h0000, 16'h00FF, 16'hBFFF, 16'hFFFF, 16'h0000, 16'h0000};
	// ==========================================================
	// Carriers
	typedef struct packed {
		lane_t en;
		lane_t data;
	} alt_ctrl_t;
	typedef struct packed {
		lane_t en;
		lane_t out;
		lane_t data;
	} hw_ctrl_t;
	typedef alt_ctrl_t [PORT_COUNT-1:0] alt_bus_t;
	typedef hw_ctrl_t [PORT_COUNT-1:0] hw_bus_t;
endpackage : parallel_io_pkg

// ### design/parallel_io_port_logic.sv
// Parallel port block: registers, sampling and pad control
// Contract
// - Sample every pin every clock cycle
// - Input line: write latch, read pin
// - Input line read-modify-write uses pin value
// - Direction one enables driver with latch value
// - Output line reads return latch contents
// - Output line read-modify-write uses latch
// - Ports 2,3,4,6,7,8 select open drain
// - Standard threshold default, hysteresis selectable
// - Threshold selected per byte of port; port 6 has no select bit and stays on standard threshold
// - Direction, drive independent of threshold
// - Alternate output needs direction one
// - Reset-critical signals switch to output automatically
// - Latch ANDed with alternate data, except modulators
// - Direction resets to input, zero means input
// - Output line feeds latch to alternate input
// - Bus lines switch direction by hardware
// - Port widths; port 3 line 14 absent
// - Port 5 input only, no drivers
// - Ports 0 and 1 addressable as halves
// - Port 4 carries upper segment address
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module parallel_io_port_logic
	import parallel_io_pkg::*;
#(
	parameter lane_arr_t PWM_LINES = '0,
	parameter lane_arr_t AUTO_LINES = '0
) (
	input logic core_clk_i,
	input logic sys_rst_i,
	input logic [ADDR_W-1:0] addr_i,
	input logic [LANE_W-1:0] wr_data_i,
	input logic wr_en_i,
	input logic rd_en_i,
	output logic [LANE_W-1:0] rd_data_o,
	input lane_arr_t pin_i,
	output lane_arr_t pin_o,
	output lane_arr_t pin_oe_o,
	input alt_bus_t alt_out_i,
	output lane_arr_t alt_in_o,
	input hw_bus_t hw_i,
	input logic seg_en_i,
	input logic [7:0] seg_addr_i
);
	// ==========================================================
	// Register state
	typedef struct packed {
		lane_arr_t latch;
		lane_arr_t dir;
		lane_arr_t od;
		logic [THR_W-1:0] thr;
		logic [XTHR_W-1:0] xthr;
		lane_t rdata;
	} regs_t;
	localparam regs_t REGS_RST = '{
		latch: {PORT_COUNT{LATCH_RST}},
		dir: {PORT_COUNT{DIR_RST}},
		od: {PORT_COUNT{OD_RST}},
		thr: '0,
		xthr: '0,
		rdata: '0
	};
	regs_t st_r;
	regs_t st_nxt;
	lane_arr_t level;
	hw_bus_t hw_eff;
	lane_t view_p0;
	lane_t view_p1;
	// ==========================================================
	// Decoding
	function automatic logic port_hit(input logic [ADDR_W-1:0] a,
		input logic [3:0] ofs);
		port_hit = (int'(a[7:4]) < PORT_COUNT) && (a[3:0] == ofs);
	endfunction : port_hit
	// Software view of a port: latch where driven, pin where input
	function automatic lane_t view(input lane_t latch, input lane_t dir,
		input lane_t pin, input lane_t impl);
		view = ((dir & latch) | (~dir & pin)) & impl;
	endfunction : view
	// Hysteresis select per lane, one bit per byte; port 6 has none
	function automatic lane_t hys_lanes(input int p,
		input logic [THR_W-1:0] t, input logic [XTHR_W-1:0] x);
		case (p)
			0: hys_lanes = {{8{t[THR_PORT0_HIGH_HALF]}}, {8{t[THR_PORT0_LOW_HALF]}}};
			1: hys_lanes = {{8{t[THR_PORT1_HIGH_HALF]}}, {8{t[THR_PORT1_LOW_HALF]}}};
			2: hys_lanes = {{8{t[THR_P2H]}}, {8{t[THR_P2L]}}};
			3: hys_lanes = {{8{t[THR_P3H]}}, {8{t[THR_P3L]}}};
			4: hys_lanes = {8'h00, {8{t[THR_P4]}}};
			5: hys_lanes = {{8{x[XTHR_P5H]}}, {8{x[XTHR_P5L]}}};
			7: hys_lanes = {8'h00, {8{x[XTHR_P7]}}};
			8: hys_lanes = {8'h00, {8{x[XTHR_P8]}}};
			default: hys_lanes = 16'h0000;
		endcase
	endfunction : hys_lanes
	// ==========================================================
	// Register next state
	// Half-port reads need the whole word view first
	assign view_p0 = view(st_r.latch[0], st_r.dir[0], level[0],
		IMPL_MASK[0]);
	assign view_p1 = view(st_r.latch[1], st_r.dir[1], level[1],
		IMPL_MASK[1]);
	always_comb begin
		logic [3:0] wp;
		wp = addr_i[7:4];
		st_nxt = st_r;
		st_nxt.rdata = 16'h0000;
		if (wr_en_i) begin
			// Writes only reach the latch; the pin follows via direction
			if (port_hit(addr_i, OFS_DATA)) begin
				st_nxt.latch[wp] = wr_data_i & DRIVE_MASK[wp];
			end
			if (port_hit(addr_i, OFS_DIR)) begin
				st_nxt.dir[wp] = wr_data_i & DRIVE_MASK[wp];
			end
			if (port_hit(addr_i, OFS_OD)) begin
				st_nxt.od[wp] = wr_data_i & OD_MASK[wp];
			end
			case (addr_i)
				ADDR_THR: begin
					st_nxt.thr = wr_data_i[THR_W-1:0];
				end
				ADDR_XTHR: begin
					st_nxt.xthr = wr_data_i[XTHR_W-1:0];
				end
				ADDR_PORT0_LOW_HALF: begin
					st_nxt.latch[0][7:0] = wr_data_i[7:0];
				end
				ADDR_PORT0_HIGH_HALF: begin
					st_nxt.latch[0][15:8] = wr_data_i[7:0];
				end
				ADDR_PORT1_LOW_HALF: begin
					st_nxt.latch[1][7:0] = wr_data_i[7:0];
				end
				ADDR_PORT1_HIGH_HALF: begin
					st_nxt.latch[1][15:8] = wr_data_i[7:0];
				end
				default: begin
				end
			endcase
		end
		if (rd_en_i) begin
			// A later write of this word completes a read-modify-write
			if (port_hit(addr_i, OFS_DATA)) begin
				st_nxt.rdata = view(st_r.latch[wp], st_r.dir[wp],
					level[wp], IMPL_MASK[wp]);
			end
			if (port_hit(addr_i, OFS_DIR)) begin
				st_nxt.rdata = st_r.dir[wp];
			end
			if (port_hit(addr_i, OFS_OD)) begin
				st_nxt.rdata = st_r.od[wp];
			end
			case (addr_i)
				ADDR_THR: begin
					st_nxt.rdata = {7'h00, st_r.thr};
				end
				ADDR_XTHR: begin
					st_nxt.rdata = {12'h000, st_r.xthr};
				end
				ADDR_PORT0_LOW_HALF: begin
					st_nxt.rdata = {8'h00, view_p0[7:0]};
				end
				ADDR_PORT0_HIGH_HALF: begin
					st_nxt.rdata = {8'h00, view_p0[15:8]};
				end
				ADDR_PORT1_LOW_HALF: begin
					st_nxt.rdata = {8'h00, view_p1[7:0]};
				end
				ADDR_PORT1_HIGH_HALF: begin
					st_nxt.rdata = {8'h00, view_p1[15:8]};
				end
				default: begin
				end
			endcase
		end
		if (sys_rst_i) begin
			st_nxt = REGS_RST;
		end
	end
	always_ff @(posedge core_clk_i) begin
		st_r <= st_nxt;
	end
	assign rd_data_o = st_r.rdata;
	// ==========================================================
	// Hardware-owned lanes; segment address overrides port 4 while seg_en_i is set
	always_comb begin
		hw_eff = hw_i;
		if (seg_en_i) begin
			hw_eff[4].en = 16'h00FF;
			hw_eff[4].out = 16'h00FF;
			hw_eff[4].data = {8'h00, seg_addr_i};
		end
	end
	// ==========================================================
	// Per-port lanes
	generate
		for (genvar g = 0; g < PORT_COUNT; g++) begin : g_port
			line_sampler #(
				.W(LANE_W)
			) u_samp (
				.core_clk_i(core_clk_i),
				.sys_rst_i(sys_rst_i),
				.pin_i(pin_i[g] & IMPL_MASK[g]),
				.hys_i(hys_lanes(g, st_r.thr, st_r.xthr)),
				.level_o(level[g])
			);
			line_pad #(
				.W(LANE_W),
				.DRIVE_LINES(DRIVE_MASK[g]),
				.OD_LINES(OD_MASK[g]),
				.PWM_LINES(PWM_LINES[g]),
				.AUTO_LINES(AUTO_LINES[g] & DRIVE_MASK[g])
			) u_pad (
				.core_clk_i(core_clk_i),
				.sys_rst_i(sys_rst_i),
				.latch_i(st_r.latch[g]),
				.dir_i(st_r.dir[g]),
				.od_i(st_r.od[g]),
				.alt_en_i(alt_out_i[g].en),
				.alt_data_i(alt_out_i[g].data),
				.hw_en_i(hw_eff[g].en & DRIVE_MASK[g]),
				.hw_out_i(hw_eff[g].out),
				.hw_data_i(hw_eff[g].data),
				.pin_o(pin_o[g]),
				.pin_oe_o(pin_oe_o[g])
			);
			// Alternate inputs see the pin, which carries the latch when driven
			assign alt_in_o[g] = level[g];
		end
	endgenerate
	// ==========================================================
	// Checks
	property p_dir_reset;
		@(posedge core_clk_i)
		sys_rst_i |=> st_r.dir == '0;
	endproperty
	a_dir_reset: assert property (p_dir_reset)
		else $error("direction not input after reset");
	property p_write_latch;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr_en_i && addr_i == ADDR_P2_DATA) |=>
			st_r.latch[2] == $past(wr_data_i);
	endproperty
	a_write_latch: assert property (p_write_latch)
		else $error("port write did not reach the latch");
	property p_read_output;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(rd_en_i && addr_i == ADDR_P2_DATA && st_r.dir[2] == 16'hFFFF)
			|=> rd_data_o == $past(st_r.latch[2]);
	endproperty
	a_read_output: assert property (p_read_output)
		else $error("output line read did not return latch");
	property p_read_input;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(rd_en_i && addr_i == ADDR_P2_DATA && st_r.dir[2] == 16'h0000)
			|=> rd_data_o == $past(level[2]);
	endproperty
	a_read_input: assert property (p_read_input)
		else $error("input line read did not return pin");
	property p_missing_line;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!pin_oe_o[3][14] && !st_r.latch[3][14] && !alt_in_o[3][14];
	endproperty
	a_missing_line: assert property (p_missing_line)
		else $error("absent port 3 line is active");
	property p_input_only;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		pin_oe_o[5] == '0;
	endproperty
	a_input_only: assert property (p_input_only)
		else $error("port 5 drove a pin");
	property p_half_write;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr_en_i && addr_i == ADDR_PORT0_HIGH_HALF) |=>
			st_r.latch[0] == {$past(wr_data_i[7:0]),
				$past(st_r.latch[0][7:0])};
	endproperty
	a_half_write: assert property (p_half_write)
		else $error("high half write disturbed the low half");
	property p_segment;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		seg_en_i ##1 seg_en_i |=> pin_oe_o[4][7:0] == 8'hFF
			&& pin_o[4][7:0] == $past(seg_addr_i);
	endproperty
	a_segment: assert property (p_segment)
		else $error("segment address not on port 4");
	property p_od_mask;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(st_r.od & ~OD_MASK) == '0;
	endproperty
	a_od_mask: assert property (p_od_mask)
		else $error("open drain bit set on a push-pull only line");
	property p_od_write;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr_en_i && addr_i == {4'h2, OFS_OD}) |=>
			st_r.od[2] == $past(wr_data_i);
	endproperty
	a_od_write: assert property (p_od_write)
		else $error("open drain write lost on port 2");
	property p_dir_mask;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(st_r.dir & ~DRIVE_MASK) == '0;
	endproperty
	a_dir_mask: assert property (p_dir_mask)
		else $error("direction bit set on a line without driver");
	property p_thr_write;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr_en_i && addr_i == ADDR_THR) |=>
			st_r.thr == $past(wr_data_i[THR_W-1:0]);
	endproperty
	a_thr_write: assert property (p_thr_write)
		else $error("threshold select write lost");
	property p_xthr_write;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr_en_i && addr_i == ADDR_XTHR) |=>
			st_r.xthr == $past(wr_data_i[XTHR_W-1:0]);
	endproperty
	a_xthr_write: assert property (p_xthr_write)
		else $error("extended threshold select write lost");
	property p_dir_write;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(wr_en_i && addr_i == {4'h2, OFS_DIR}) |=>
			st_r.dir[2] == $past(wr_data_i);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("direction write lost on port 2");
	property p_rd_idle;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!rd_en_i |=> rd_data_o == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data present without a read");
	property p_high_half_read;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(rd_en_i && addr_i == ADDR_PORT0_HIGH_HALF
			&& st_r.dir[0] == 16'hFFFF) |=>
			rd_data_o == {8'h00, $past(st_r.latch[0][15:8])};
	endproperty
	a_high_half_read: assert property (p_high_half_read)
		else $error("high half read did not return upper byte");
	property p_bus_lane;
		@(posedge core_clk_i) disable iff (sys_rst_i)
		(hw_i[0].en == 16'hFFFF && hw_i[0].out == 16'hFFFF) |=>
			pin_oe_o[0] == 16'hFFFF;
	endproperty
	a_bus_lane: assert property (p_bus_lane)
		else $error("bus lanes not switched to output");
endmodule : parallel_io_port_logic

// ### tb/pin_partner.sv
// External devices and pull-ups on the port pins
`timescale 1ns/10ps
module pin_partner
	import parallel_io_pkg::*;
(
	input lane_arr_t drv_i,
	input lane_arr_t drv_oe_i,
	input lane_arr_t ext_i,
	input lane_arr_t ext_en_i,
	output lane_arr_t wire_o
);
	// ==========================================================
	// Wire resolution
	// Board pull-ups on every line, so released lines read high
	assign wire_o = (drv_oe_i & drv_i)
		| (~drv_oe_i & ext_en_i & ext_i)
		| (~drv_oe_i & ~ext_en_i);
endmodule : pin_partner

// ### tb/tb_parallel_io_port_logic.sv
// Self-checking bench for the parallel port block
`timescale 1ns/10ps
module tb_parallel_io_port_logic;
	import parallel_io_pkg::*;
	// ==========================================================
	// Signals
	localparam lane_arr_t PWM_P = {16'h0000, 16'h0001, {7{16'h0000}}};
	localparam lane_arr_t AUTO_P = {{5{16'h0000}}, 16'h0001, {3{16'h0000}}};
	logic core_clk_i;
	logic sys_rst_i;
	logic [ADDR_W-1:0] addr_i;
	lane_t wr_data_i;
	logic wr_en_i;
	logic rd_en_i;
	lane_t rd_data_o;
	lane_arr_t pin_i, pin_o, pin_oe_o, alt_in_o, ext, ext_en;
	alt_bus_t alt;
	hw_bus_t hw;
	logic seg_en;
	logic [7:0] seg_addr;
	int num_errors;
	int n_compared;
	lane_t exp_q[$];
	logic pend;
	lane_t d, e, l, a, acc;
	// ==========================================================
	// Design and far side
	parallel_io_port_logic #(.PWM_LINES(PWM_P), .AUTO_LINES(AUTO_P)) dut (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
		.rd_data_o(rd_data_o), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe_o(pin_oe_o), .alt_out_i(alt), .alt_in_o(alt_in_o),
		.hw_i(hw), .seg_en_i(seg_en), .seg_addr_i(seg_addr));
	pin_partner far (.drv_i(pin_o), .drv_oe_i(pin_oe_o), .ext_i(ext),
		.ext_en_i(ext_en), .wire_o(pin_i));
	// ==========================================================
	// Clock, shared tasks
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	task automatic check(input lane_t got, input lane_t exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] ad, input lane_t dv);
		@(posedge core_clk_i);
		addr_i <= ad;
		wr_data_i <= dv;
		wr_en_i <= 1'b1;
		@(posedge core_clk_i);
		wr_en_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] ad, input lane_t ex);
		@(posedge core_clk_i);
		addr_i <= ad;
		rd_en_i <= 1'b1;
		exp_q.push_back(ex);
		@(posedge core_clk_i);
		rd_en_i <= 1'b0;
	endtask : rd
	task automatic settle();
		repeat (8) @(posedge core_clk_i);
	endtask : settle
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// ==========================================================
	// Read data monitor: one cycle after each read strobe
	always @(posedge core_clk_i) begin
		if (pend === 1'b1 && exp_q.size() > 0)
			check(rd_data_o, exp_q.pop_front());
		pend <= rd_en_i;
	end
	initial begin
		#100000;
		num_errors++;
		finish_test();
	end
	// ==========================================================
	// Tests
	initial begin
		sys_rst_i = 1'b1;
		addr_i = '0;
		wr_data_i = '0;
		wr_en_i = 1'b0;
		rd_en_i = 1'b0;
		ext = '0;
		ext_en = '0;
		alt = '0;
		hw = '0;
		seg_en = 1'b0;
		seg_addr = '0;
		num_errors = 0;
		n_compared = 0;
		void'($urandom(32'hea3f));
		repeat (20) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		// Reset state, released pins pulled high
		rd(8'h24, 16'h0000);
		rd(8'h28, 16'h0000);
		rd(ADDR_THR, 16'h0000);
		rd(8'h20, 16'hffff);
		for (int p = 0; p < PORT_COUNT; p++)
			check(pin_oe_o[p], 16'h0000);
		$display("test reset done");
		// Short glitch passes low byte only with hysteresis on high
		wr(ADDR_THR, 16'h0001 << THR_P2H);
		ext_en[2] <= 16'hffff;
		settle();
		acc = '0;
		ext[2] <= 16'hffff;
		repeat (2) @(posedge core_clk_i);
		ext[2] <= 16'h0000;
		repeat (10) begin
			@(posedge core_clk_i);
			acc = acc | alt_in_o[2];
		end
		check(acc, 16'h00ff);
		wr(ADDR_THR, 16'h0000);
		wr(ADDR_XTHR, 16'h000f);
		rd(ADDR_XTHR, 16'h000f);
		wr(ADDR_XTHR, 16'h0000);
		$display("test threshold done");
		// Input then output use of port 2
		e = $urandom;
		d = $urandom;
		ext[2] <= e;
		wr(8'h20, d);
		settle();
		check(pin_oe_o[2], 16'h0000);
		rd(8'h20, e);
		wr(8'h20, e ^ 16'h0f0f);
		ext_en[2] <= 16'h0000;
		wr(8'h24, 16'hffff);
		settle();
		rd(8'h20, e ^ 16'h0f0f);
		check(pin_oe_o[2], 16'hffff);
		check(pin_o[2], e ^ 16'h0f0f);
		check(alt_in_o[2], e ^ 16'h0f0f);
		d = $urandom;
		ext[2] <= d;
		ext_en[2] <= 16'hff00;
		wr(8'h24, 16'h00ff);
		settle();
		rd(8'h20, ((e ^ 16'h0f0f) & 16'h00ff) | (d & 16'hff00));
		ext_en[2] <= 16'h0000;
		$display("test direction done");
		// Open drain, masked and absent lines; direction under hysteresis
		wr(ADDR_THR, 16'hffff);
		wr(8'h24, 16'hffff);
		wr(8'h28, 16'hffff);
		wr(8'h20, 16'h00f0);
		settle();
		check(pin_oe_o[2], 16'hff0f);
		check(pin_o[2], 16'h0000);
		rd(8'h28, 16'hffff);
		wr(8'h08, 16'hffff);
		rd(8'h08, 16'h0000);
		wr(8'h54, 16'hffff);
		wr(8'h50, 16'hffff);
		rd(8'h54, 16'h0000);
		wr(8'h34, 16'hffff);
		rd(8'h34, 16'hbfff);
		wr(8'h44, 16'hffff);
		rd(8'h44, 16'h00ff);
		rd(8'hf0, 16'h0000);
		rd(8'h7c, 16'h0000);
		settle();
		check(pin_oe_o[5], 16'h0000);
		check(pin_oe_o[3], 16'hbfff);
		wr(ADDR_THR, 16'h0000);
		$display("test masks done");
		// Alternate outputs, modulator line, automatic direction
		l = $urandom;
		a = $urandom;
		wr(8'h70, l);
		alt[7] <= '{en: 16'hffff, data: a};
		wr(8'h34, 16'h0000);
		alt[3] <= '{en: 16'h0001, data: 16'h0001};
		settle();
		check(pin_oe_o[7], 16'h0000);
		check(pin_oe_o[3], 16'h0001);
		rd(8'h34, 16'h0000);
		wr(8'h74, 16'h00ff);
		settle();
		check(pin_oe_o[7], 16'h00ff);
		check(pin_o[7], (l & a & 16'h00fe) | (a & 16'h0001));
		$display("test alternate done");
		// Byte halves of ports 0 and 1
		wr(8'h04, 16'hffff);
		wr(ADDR_PORT0_LOW_HALF, 16'h003c);
		wr(ADDR_PORT0_HIGH_HALF, 16'h005a);
		rd(8'h00, 16'h5a3c);
		rd(ADDR_PORT0_HIGH_HALF, 16'h005a);
		wr(8'h14, 16'hffff);
		wr(ADDR_PORT1_HIGH_HALF, 16'h00c3);
		wr(ADDR_PORT1_LOW_HALF, 16'h0096);
		rd(8'h10, 16'hc396);
		rd(ADDR_PORT1_LOW_HALF, 16'h0096);
		$display("test halves done");
		// Hardware-owned bus and segment lines
		d = $urandom;
		seg_addr <= d[7:0];
		seg_en <= 1'b1;
		hw[0] <= '{en: 16'hffff, out: 16'hffff, data: e};
		wr(8'h04, 16'h0000);
		wr(8'h44, 16'h0000);
		settle();
		check(pin_oe_o[0], 16'hffff);
		check(pin_o[0], e);
		check(pin_oe_o[4], 16'h00ff);
		check(pin_o[4], {8'h00, d[7:0]});
		hw[0] <= '{en: 16'hffff, out: 16'h0000, data: e};
		settle();
		check(pin_oe_o[0], 16'h0000);
		$display("test hardware done");
		repeat (4) @(posedge core_clk_i);
		finish_test();
	end
endmodule : tb_parallel_io_port_logic
